// *** cca_bus_adapter.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - address drives mux lines during latch enable
// - read with held select: mux to cpu
// - write with held select: cpu to mux
// - no transfer: latched address held on mux
// - divide clock to cipher rate, strobe synced
// - registered outputs change before strobes end
// - counter reloads on latch with raw select
// - three bits form a down counter
// - ready is inverted counter msb and held select
// - cipher clock half period two cycles, one cycle for the first low phase when a wait state is skipped
// - mid bit next-value equation
// - low bit toggles, realigned at latch
// - mid bit is low divided by two
// - high bit is mid divided by two
// - hold-off pulse one clock when selected
// - fewer wait states except control reads
// - held select captured at latch enable
module cca_bus_adapter (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // processor bus control
    input wire cca_pkg::cca_bus_ctl_t bus_ctl,
    input wire logic [1:0] reg_addr,
    // processor data pins, split into in, out and enable
    input wire logic [1:0] cpu_data_in,
    output logic [1:0] cpu_data_out,
    output logic cpu_data_oe,
    // cipher multiplexed pins, split into in, out and enable
    input wire logic [1:0] mux_line_in,
    output logic [1:0] mux_line_out,
    output logic mux_line_oe,
    // cipher control
    output logic master_port_select,
    output logic cipher_clock,
    output logic chip_select_held,
    output logic count_msb,
    output logic sync_ready_out,
    output logic strobe_hold_off
);

    ////////////////////////////////////////////////////////////////////////////
    // decoded bus conditions; all are plain levels sampled on the rising edge
    wire logic ale = bus_ctl.addr_latch_enable;
    wire logic cs_raw = bus_ctl.chip_select_raw;
    wire logic rd_strobe = bus_ctl.io_read_strobe;
    wire logic wr_strobe = bus_ctl.io_write_strobe;

    // a latch pulse together with the raw select reloads the counter
    wire logic load_cnt = ale && cs_raw;

    // strobes only count once the held select qualifies them; an unselected
    // cycle therefore never turns the lines around
    wire logic rd_q = rd_strobe && chip_select_held;
    wire logic wr_q = wr_strobe && chip_select_held;

    ////////////////////////////////////////////////////////////////////////////
    // internal state
    logic ale_d;
    logic [2:0] cnt;
    logic [1:0] addr_hold;
    logic ctrl_read;
    logic [1:0] hold_cnt;

    // latch enable history; the rising edge closes the previous cycle's held
    // select, so the select stays valid right up to the next latch pulse
    wire logic ale_rise = ale && !ale_d;

    // a control register read is the only access that keeps the full wait
    wire logic ctrl_rd_now = ctrl_read && rd_strobe;

    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    // counter next value; mid bit follows the sum-of-products form, the low bit is a plain
    // toggle and the high bit toggles when low and mid are both zero, so all three read as a down counter
    function automatic logic [2:0] cca_next_count(input logic [2:0] c);
        logic [2:0] n;
        n = c;
        n[cca_pkg::CNT_LOW] = !c[cca_pkg::CNT_LOW];
        n[cca_pkg::CNT_MID] = (c[cca_pkg::CNT_LOW] && c[cca_pkg::CNT_MID])
                             || (!c[cca_pkg::CNT_LOW] && !c[cca_pkg::CNT_MID]);
        n[cca_pkg::CNT_HIGH] = c[cca_pkg::CNT_HIGH]
                              ^ (!c[cca_pkg::CNT_LOW] && !c[cca_pkg::CNT_MID]);
        return n;
    endfunction

    // multiplexer direction; a write wins over a read so that overlapping
    // strobes never leave both sides driving the lines at once
    function automatic cca_pkg::cca_dir_t cca_dir_decode(input logic rd, input logic wr);
        cca_pkg::cca_dir_t d;
        d = cca_pkg::CCA_DIR_ADDR;
        if (wr) begin
            d = cca_pkg::CCA_DIR_WRITE;
        end else if (rd) begin
            d = cca_pkg::CCA_DIR_READ;
        end
        return d;
    endfunction

    // value for the cipher lines: write data, the live address during the
    // latch pulse, or the held address for hold time after it
    function automatic logic [1:0] cca_mux_select(input cca_pkg::cca_dir_t d,
                                                  input logic latch,
                                                  input logic [1:0] wdata,
                                                  input logic [1:0] live,
                                                  input logic [1:0] held);
        logic [1:0] v;
        v = held;
        if (d == cca_pkg::CCA_DIR_WRITE) begin
            v = wdata;
        end else if (latch) begin
            v = live;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // counter next value

    // at terminal count the counter parks so ready stays up for the rest of
    // the cycle; only a selected latch pulse can restart it
    wire logic at_term = (cnt == cca_pkg::CNT_TERM);

    // one and two steps ahead; the second is used to drop a wait state
    wire logic [2:0] step1 = cca_next_count(cnt);
    wire logic [2:0] step2 = cca_next_count(step1);

    // the skip is taken on the first step after the load, while the high bit
    // is still set, so ready rises one clock earlier; a control read keeps the
    // full count because the cipher side needs the longer strobe there
    wire logic at_init = (cnt == cca_pkg::CNT_INIT);
    wire logic skip_ws = at_init && !ctrl_rd_now;

    // load wins over parking and counting
    wire logic [2:0] next_cnt = load_cnt ? cca_pkg::CNT_INIT
                              : at_term ? cnt
                              : (skip_ws ? step2 : step1);

    ////////////////////////////////////////////////////////////////////////////
    // multiplexer direction and drive values
    wire cca_pkg::cca_dir_t dir = cca_dir_decode(rd_q, wr_q);
    wire logic dir_is_read = (dir == cca_pkg::CCA_DIR_READ);

    // address during latch, write data on a write, held address otherwise
    wire logic [1:0] next_mux_out = cca_mux_select(dir, ale, cpu_data_in, reg_addr,
                                                   addr_hold);

    // the lines are released only while the cipher side answers a read
    wire logic next_mux_oe = !dir_is_read;
    wire logic next_cpu_oe = dir_is_read;

    // hold-off stays up for the configured number of clocks after the load
    wire logic hold_running = (hold_cnt != 2'h0) && (hold_cnt < cca_pkg::HOLD_OFF_CYC);
    wire logic next_hold_off = load_cnt || hold_running;

    // the hold-off counter runs from the load and stops by wrapping to zero
    wire logic [2:0] hold_sum = {1'b0, hold_cnt} + 3'h1;
    wire logic [1:0] next_hold_cnt = load_cnt ? 2'h1
                                   : (hold_cnt != 2'h0) ? hold_sum[1:0] : 2'h0;

    // counter-derived outputs; the cipher clock is the inverted mid bit
    wire logic next_cipher_clock = !next_cnt[cca_pkg::CNT_MID];
    wire logic next_count_msb = !next_cnt[cca_pkg::CNT_HIGH];

    // ready gated with held select; the far end samples it on the falling
    // edge, half a clock after this flop changes, which keeps setup and hold
    wire logic next_ready = next_count_msb && chip_select_held;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // latch enable history for the rising edge detector
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ale_d <= 1'b0;
        end else begin
            ale_d <= ale;
        end
    end

    // held chip select, captured at each latch pulse for the whole cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chip_select_held <= 1'b0;
        end else if (ale_rise) begin
            chip_select_held <= cs_raw;
        end
    end

    // register class of the access, taken with the held select
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_read <= 1'b0;
        end else if (ale_rise) begin
            ctrl_read <= reg_addr[cca_pkg::CTRL_ADDR_BIT];
        end
    end

    // latched address so it stays on the lines after latch enable falls
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_hold <= 2'h0;
        end else if (ale) begin
            addr_hold <= reg_addr;
        end
    end

    // state counter, rising edge; output changes one edge before strobe ends
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= cca_pkg::CNT_RESET;
        end else begin
            cnt <= next_cnt;
        end
    end

    // hold-off length counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_cnt <= 2'h0;
        end else begin
            hold_cnt <= next_hold_cnt;
        end
    end

    // strobe hold-off pulse, one clock per selected latch; a latch enable that
    // stays high for two clocks does not stretch it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_hold_off <= 1'b0;
        end else begin
            strobe_hold_off <= next_hold_off && !ale_d;
        end
    end

    // cipher line drive value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mux_line_out <= 2'h0;
        end else begin
            mux_line_out <= next_mux_out;
        end
    end

    // cipher line enable; reset loads it low, after that low only while a qualified read is under way
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mux_line_oe <= 1'b0;
        end else begin
            mux_line_oe <= next_mux_oe;
        end
    end

    // read data passes through one flop, so it lags the lines by one clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_data_out <= 2'h0;
        end else begin
            cpu_data_out <= mux_line_in;
        end
    end

    // processor data enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_data_oe <= 1'b0;
        end else begin
            cpu_data_oe <= next_cpu_oe;
        end
    end

    // cipher port select follows the raw decoder, never the held copy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            master_port_select <= 1'b0;
        end else begin
            master_port_select <= cs_raw;
        end
    end

    // cipher clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cipher_clock <= 1'b0;
        end else begin
            cipher_clock <= next_cipher_clock;
        end
    end

    // inverted counter msb, offered for external ready gating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_msb <= 1'b0;
        end else begin
            count_msb <= next_count_msb;
        end
    end

    // synchronous ready
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_ready_out <= 1'b0;
        end else begin
            sync_ready_out <= next_ready;
        end
    end

endmodule // cca_bus_adapter

// *** cca_pkg.sv ***
package cca_pkg;

    // width of the cipher register address and of the data slice handled here
    localparam int ADDR_W = 2;

    // system clock figures
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;

    // minimum cipher clock high or low time and its cycle count
    localparam int CIPHER_HALF_MIN_NS = 115;
    localparam int CIPHER_HALF_MIN_CYC_RAW = (CIPHER_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CIPHER_HALF_MIN_CYC = (CIPHER_HALF_MIN_CYC_RAW < 1) ? 1 : CIPHER_HALF_MIN_CYC_RAW;

    // down counter layout and load value
    localparam int CNT_W = 3;
    localparam int CNT_LOW = 0;
    localparam int CNT_MID = 1;
    localparam int CNT_HIGH = 2;
    localparam logic [2:0] CNT_INIT = 3'h7;
    localparam logic [2:0] CNT_TERM = 3'h0;
    localparam logic [2:0] CNT_RESET = 3'h0;

    // length of the strobe hold-off pulse in system clocks
    localparam logic [1:0] HOLD_OFF_CYC = 2'h1;

    // wait-state policy: address of the control registers has this bit set
    localparam int CTRL_ADDR_BIT = 0;

    // processor bus control inputs
    typedef struct packed {
        logic addr_latch_enable;
        logic io_read_strobe;
        logic io_write_strobe;
        logic chip_select_raw;
    } cca_bus_ctl_t;

    // direction of the multiplexer
    typedef enum logic [1:0] {
        CCA_DIR_ADDR = 2'b00,
        CCA_DIR_READ = 2'b01,
        CCA_DIR_WRITE = 2'b11
    } cca_dir_t;

endpackage

// *** cca_bus_adapter_asserts.sv ***
`timescale 1ns/1ps
module cca_bus_adapter_chk (
    // adapter ports, watched only
    input wire logic clk,
    input wire logic reset_n,
    input wire cca_pkg::cca_bus_ctl_t bus_ctl,
    input wire logic [1:0] reg_addr,
    input wire logic cpu_data_oe,
    input wire logic [1:0] mux_line_out,
    input wire logic mux_line_oe,
    input wire logic master_port_select,
    input wire logic count_msb,
    input wire logic strobe_hold_off,
    input wire logic chip_select_held
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a strobe only turns the lines together with the held select
    wire ale = bus_ctl.addr_latch_enable;
    wire ld = ale && bus_ctl.chip_select_raw;
    wire rd = bus_ctl.io_read_strobe && chip_select_held;
    wire wr = bus_ctl.io_write_strobe && chip_select_held;
    sequence s_pulse;
        strobe_hold_off ##1 !strobe_hold_off;
    endsequence
    AST_ADDR: assert property (
        ale |=> mux_line_oe && mux_line_out == $past(reg_addr)) else $error("no address");
    AST_READ: assert property (
        rd |=> cpu_data_oe && !mux_line_oe) else $error("read not turned");
    AST_WRITE: assert property (
        wr |=> mux_line_oe && !cpu_data_oe) else $error("write not turned");
    AST_IDLE: assert property (
        !rd && !wr |=> mux_line_oe && !cpu_data_oe) else $error("address not held");
    AST_SEL: assert property (
        master_port_select == $past(bus_ctl.chip_select_raw)) else $error("port select");
    AST_LOAD: assert property (
        ld |=> !count_msb) else $error("no reload");
    AST_PULSE: assert property (
        ld |=> s_pulse) else $error("hold-off pulse");
    AST_PARK: assert property (
        count_msb && !ld |=> count_msb) else $error("left terminal count");
endmodule // cca_bus_adapter_chk
bind cca_bus_adapter cca_bus_adapter_chk cca_bus_adapter_chk_inst (.*);

// *** cca_cipher_model.sv ***
`timescale 1ns/1ps
module cca_cipher_model (
    // bus side
    input wire logic clk,
    input wire logic ale,
    input wire logic read,
    input wire logic sel,
    // lines as the adapter drives them, and as they settle
    input wire logic [1:0] mux_out,
    input wire logic mux_oe,
    output logic [1:0] mux_wire
);
    logic ale_d = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [1:0] last = 2'h0;
    // register address taken as the latch enable falls
    always @(posedge clk) begin
        ale_d <= ale;
        last <= mux_wire;
        if (ale_d && !ale) addr <= mux_wire;
    end
    // selected read returns ~addr; released lines flip so stale data never passes
    assign mux_wire = mux_oe ? mux_out : (read && sel) ? ~addr : ~last;
endmodule // cca_cipher_model

// *** cca_bus_adapter_tb_top.sv ***
`timescale 1ns/1ps
module cca_bus_adapter_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    cca_pkg::cca_bus_ctl_t bus_ctl = '0;
    logic [1:0] reg_addr = 2'h0;
    logic [1:0] cpu_data_out, mux_line_in, mux_line_out;
    logic cpu_data_oe, mux_line_oe, master_port_select, cipher_clock;
    logic chip_select_held, count_msb, sync_ready_out, strobe_hold_off;
    int fail_count = 0;
    int samples_checked = 0;
    // released data pins carry the bench's write data, ~address
    wire [1:0] cpu_data_in = cpu_data_oe ? cpu_data_out : ~reg_addr;
    always #25 clk = ~clk;
    cca_bus_adapter cca_bus_adapter_inst (.*);
    cca_cipher_model cca_cipher_model_inst (.clk, .ale(bus_ctl.addr_latch_enable),
        .read(bus_ctl.io_read_strobe), .sel(master_port_select), .mux_out(mux_line_out),
        .mux_oe(mux_line_oe), .mux_wire(mux_line_in));
////////////////////////////////////////
    // compare and count
    task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    // verdict and end of run
    task automatic wrap_up();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // latch cycle then strobe; n counts clocks until ready comes back
    task automatic cyc(logic [1:0] a, logic cs, logic [1:0] strb, output int n);
        logic lo;
        lo = 1'b0;
        n = 0;
        bus_ctl = '{1'b1, 1'b0, 1'b0, cs};
        reg_addr = a;
        @(negedge clk);
        bus_ctl = '{1'b0, strb[1], strb[0], cs};
        if (cs) begin
            check("hold_off", {1'b0, strobe_hold_off}, 2'h1);
            check("cipher_clock", {1'b0, cipher_clock}, 2'h0);
        end
        check("port_select", {1'b0, master_port_select}, {1'b0, cs});
        check("count_msb", {1'b0, count_msb}, {1'b0, !cs});
        // ready is looked at on the falling edge, as the clock generator does
        while (!(lo && sync_ready_out === 1'b1) && n < 40) begin
            lo = lo | (sync_ready_out === 1'b0);
            n++;
            @(negedge clk);
        end
        if (n == 40 && cs) begin
            fail_count++;
            wrap_up();
        end
    endtask
    // read then write at one address, back to back
    task automatic t_xfer(logic [1:0] a);
        int n;
        cyc(a, 1'b1, 2'h2, n);
        @(negedge clk);
        check("read_data", cpu_data_out, ~a);
        check("ready", {sync_ready_out, chip_select_held}, 2'h3);
        cyc(a, 1'b1, 2'h1, n);
        check("write_data", mux_line_out, ~a);
        bus_ctl = '0;
        repeat (2) @(negedge clk);
        check("addr_hold", mux_line_out, a);
        check("held", {1'b0, chip_select_held}, 2'h1);
    endtask
    // control reads take one step more than data reads
    task automatic t_wait();
        int n_ctl, n_dat;
        cyc(2'h1, 1'b1, 2'h2, n_ctl);
        cyc(2'h0, 1'b1, 2'h2, n_dat);
        check("wait_gap", {1'b0, n_ctl > n_dat}, 2'h1);
    endtask
    // unselected cycle: the strobe is ignored
    task automatic t_unsel();
        int n;
        cyc(2'h2, 1'b0, 2'h2, n);
        check("unsel", {sync_ready_out, chip_select_held}, 2'h0);
        check("unsel_oe", {cpu_data_oe, mux_line_oe}, 2'h1);
        check("unsel_addr", mux_line_out, 2'h2);
    endtask
    // reset for six clocks, then the scenarios
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            t_xfer(i[1:0]);
        end
        t_wait();
        t_unsel();
        wrap_up();
    end
endmodule // cca_bus_adapter_tb_top
